// ==== inc/adc_ctrl_pkg.sv ====
// Package with register map, field positions, codes and timing counts
package adc_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CLOCK_GATE = 8'h00;
  localparam logic [7:0] OFF_SC1_U0 = 8'h04;
  localparam logic [7:0] OFF_SC2_U0 = 8'h08;
  localparam logic [7:0] OFF_CFG_U0 = 8'h0C;
  localparam logic [7:0] OFF_CMP_U0 = 8'h10;
  localparam logic [7:0] OFF_RES_U0 = 8'h14;
  localparam logic [7:0] OFF_OFS_U0 = 8'h18;
  localparam logic [7:0] OFF_CAL_U0 = 8'h1C;
  localparam logic [7:0] UNIT_STRIDE = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // status_control_one
  localparam int SC1_CH_LSB = 0;
  localparam int SC1_DIFFERENTIAL_SELECT = 5;
  localparam int SC1_IEN = 6;
  localparam int SC1_COCO = 7;
  // status_control_two
  localparam int SC2_REF_LSB = 0;
  localparam int SC2_CMP_RANGE = 4;
  localparam int SC2_CMP_GT = 5;
  localparam int SC2_CMP_EN = 6;
  localparam int SC2_TRG = 7;
  // configuration
  localparam int CFG_CLK_LSB = 0;
  localparam int CFG_DIV_LSB = 2;
  localparam int CFG_MODE_LSB = 4;
  localparam int CFG_AVG_LSB = 6;
  localparam int CFG_AVGE = 8;
  localparam int CFG_CONT = 9;
  localparam int CFG_CAL = 10;
  localparam int CFG_CALIBRATION_FAILED_FLAG = 11;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [4:0] CH_TEMP = 5'h1A;
  localparam logic [4:0] CH_BANDGAP = 5'h1B;
  localparam logic [4:0] CH_VREF_OUT = 5'h0F;
  localparam logic [4:0] CH_PAIR0 = 5'h00;
  localparam logic [4:0] CH_PAIR1 = 5'h01;
  localparam logic [5:0] SRC_VREFL = 6'h3F;
  localparam logic [1:0] REF_EXT = 2'h0;
  localparam logic [1:0] REF_RES = 2'h3;
  localparam logic [1:0] CLK_BUS_HALF = 2'h1;
  localparam logic [15:0] CAL_LIMIT = 16'h0400;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int CONV_NS = 96;
  localparam int CONV_CYCLES = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int CAL_SAMPLES = 4;

endpackage : adc_ctrl_pkg

// ==== design/adc_clock_div.sv ====
// Conversion clock source selection and divider tick generator
`timescale 1ns/1ns
module adc_clock_div (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [1:0] clk_source,
  input wire logic [1:0] clk_divider,
  input wire logic alt_tick,
  input wire logic async_tick,
  output logic conv_tick
);

  logic half_reg;
  logic half_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic src_tick;
  logic [2:0] div_max;

  // ----------------------------------------------------------------
  // Source selection and divide
  // ----------------------------------------------------------------
  always_comb begin
    half_next = ~half_reg;
    unique case (clk_source)
      2'h0: src_tick = 1'b1;
      adc_ctrl_pkg::CLK_BUS_HALF: src_tick = half_reg;
      2'h2: src_tick = alt_tick;
      2'h3: src_tick = async_tick;
    endcase
    div_max = 3'((4'h1 << clk_divider) - 4'h1);
    cnt_next = cnt_reg;
    conv_tick = 1'b0;
    if (src_tick) begin
      if (cnt_reg >= div_max) begin
        cnt_next = 3'h0;
        conv_tick = 1'b1;
      end else begin
        cnt_next = cnt_reg + 3'h1;
      end
    end
  end

  // Registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      half_reg <= 1'b0;
      cnt_reg <= 3'h0;
    end else begin
      half_reg <= half_next;
      cnt_reg <= cnt_next;
    end
  end

endmodule : adc_clock_div

// ==== design/adc_unit.sv ====
// One converter unit: channel map, trigger, averaging, calibration, compare
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module adc_unit #(
  parameter bit UNIT = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_gate,
  input wire logic [4:0] channel_select_field,
  input wire logic differential_select,
  input wire logic sc1_write,
  input wire logic trigger_source_select,
  input wire logic [1:0] reference_select,
  input wire logic [1:0] conv_clock_source,
  input wire logic [1:0] conv_clock_divider,
  input wire logic [1:0] res_mode,
  input wire logic [1:0] avg_count,
  input wire logic avg_enable,
  input wire logic continuous,
  input wire logic cal_start,
  input wire logic cmp_enable,
  input wire logic cmp_greater,
  input wire logic cmp_range,
  input wire logic [15:0] cmp_value,
  input wire logic [15:0] cmp_value_hi,
  input wire logic hw_conversion_trigger,
  input wire logic hw_trigger_select_event,
  input wire logic alt_tick,
  input wire logic async_tick,
  input wire logic [15:0] sample_data,
  input wire logic coco_clear,
  output logic [5:0] mux_source,
  output logic differential_select_pair,
  output logic [1:0] ref_pair,
  output logic [15:0] result_reg,
  output logic [15:0] offset_reg,
  output logic coco_reg,
  output logic cal_active_reg,
  output logic cal_failed_reg,
  output logic busy
);

  typedef enum logic [2:0] {
    IDLE = 3'b001,
    CONV = 3'b010,
    DONE = 3'b100
  } state_type;

  state_type state_reg, state_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [5:0] nsamp_reg, nsamp_next;
  logic [20:0] acc_reg, acc_next;
  logic [15:0] result_next, offset_next;
  logic coco_next, cal_active_next, cal_failed_next;
  logic trg_armed_reg, trg_armed_next, hwt_d_reg;
  logic tick, start, hw_edge;
  logic [5:0] target;
  logic [20:0] mean;
  logic [15:0] masked, corrected;
  logic cmp_hit;
  // Channel codes with no source per unit, routed to the low reference
  localparam logic [31:0] UNUSED_CODES = UNIT ? 32'hF20C0424 : 32'hF3CD0308;

  adc_clock_div u_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_source(conv_clock_source),
    .clk_divider(conv_clock_divider),
    .alt_tick(alt_tick),
    .async_tick(async_tick),
    .conv_tick(tick)
  );

  // ----------------------------------------------------------------
  // Channel map
  // ----------------------------------------------------------------
  always_comb begin
    differential_select_pair = 1'b0;
    ref_pair = (reference_select == adc_ctrl_pkg::REF_RES) ?
               adc_ctrl_pkg::REF_EXT : reference_select;
    mux_source = adc_ctrl_pkg::SRC_VREFL;
    if (differential_select) begin
      if (channel_select_field == (UNIT ? adc_ctrl_pkg::CH_PAIR1 : adc_ctrl_pkg::CH_PAIR0))
        begin
        differential_select_pair = 1'b1;
        mux_source = {5'h0, UNIT};
      end
    end else if (channel_select_field == (UNIT ? adc_ctrl_pkg::CH_PAIR0 :
                 adc_ctrl_pkg::CH_PAIR1)) begin
      mux_source = {5'h0, UNIT}; // Minus pin single ended
    end else if (channel_select_field == adc_ctrl_pkg::CH_TEMP ||
                 channel_select_field == adc_ctrl_pkg::CH_BANDGAP ||
                 channel_select_field == adc_ctrl_pkg::CH_VREF_OUT) begin
      mux_source = {1'b0, channel_select_field};
    end else if (UNUSED_CODES[channel_select_field]) begin
      mux_source = adc_ctrl_pkg::SRC_VREFL;
    end else begin
      mux_source = {1'b1, channel_select_field}; // Per-unit table beyond this block
    end
  end

  // ----------------------------------------------------------------
  // Conversion, averaging, calibration
  // ----------------------------------------------------------------
  assign hw_edge = hw_conversion_trigger & ~hwt_d_reg;
  assign start = clk_gate & (trigger_source_select ?
                 (hw_edge & (trg_armed_reg | hw_trigger_select_event)) :
                 sc1_write);
  assign target = (avg_enable | cal_active_reg) ?
                  6'(6'h4 << avg_count) : 6'h1;
  assign mean = acc_reg >> ({1'b0, avg_count} + 3'h2);
  assign masked = (avg_enable ? mean[15:0] : acc_reg[15:0]) &
                  (16'hFFFF << (res_mode == 2'h0 ? 4'h8 : res_mode == 2'h1 ? 4'h4 :
                   res_mode == 2'h2 ? 4'h6 : 4'h0));
  assign corrected = masked - offset_reg;
  assign cmp_hit = !cmp_enable ? 1'b1 : cmp_range ?
                   (corrected >= cmp_value && corrected <= cmp_value_hi) :
                   (cmp_greater ? corrected > cmp_value : corrected < cmp_value);
  assign busy = (state_reg != IDLE);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    nsamp_next = nsamp_reg;
    acc_next = acc_reg;
    result_next = result_reg;
    offset_next = offset_reg;
    coco_next = coco_reg & ~coco_clear;
    cal_active_next = cal_active_reg | (cal_start & clk_gate);
    cal_failed_next = cal_failed_reg;
    trg_armed_next = trg_armed_reg | hw_trigger_select_event;
    unique case (state_reg)
      IDLE: begin
        if (start | (cal_start & clk_gate)) begin
          state_next = CONV;
          cnt_next = 6'h0;
          nsamp_next = 6'h0;
          acc_next = 21'h0;
          trg_armed_next = 1'b0;
          if (cal_start) cal_failed_next = 1'b0;
        end
      end
      CONV: begin
        if (tick) cnt_next = cnt_reg + 6'h1;
        if (cnt_reg == 6'(adc_ctrl_pkg::CONV_CYCLES)) begin
          cnt_next = 6'h0;
          acc_next = acc_reg + {5'h0, sample_data};
          nsamp_next = nsamp_reg + 6'h1;
          if (nsamp_reg + 6'h1 >= target) state_next = DONE;
        end
      end
      DONE: begin
        if (cal_active_reg) begin
          offset_next = mean[15:0];
          cal_failed_next = (mean[15:0] > adc_ctrl_pkg::CAL_LIMIT);
          cal_active_next = 1'b0;
          state_next = IDLE;
        end else begin
          if (cmp_hit) begin
            result_next = corrected;
            coco_next = 1'b1; // Set wins over clear
          end
          state_next = (continuous & ~trigger_source_select) ? CONV : IDLE;
          nsamp_next = 6'h0;
          acc_next = 21'h0;
        end
      end
      default: state_next = IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= IDLE;
      cnt_reg <= 6'h0;
      nsamp_reg <= 6'h0;
      acc_reg <= 21'h0;
      result_reg <= 16'h0;
      offset_reg <= 16'h0;
      coco_reg <= 1'b0;
      cal_active_reg <= 1'b0;
      cal_failed_reg <= 1'b0;
      trg_armed_reg <= 1'b0;
      hwt_d_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      nsamp_reg <= nsamp_next;
      acc_reg <= acc_next;
      result_reg <= result_next;
      offset_reg <= offset_next;
      coco_reg <= coco_next;
      cal_active_reg <= cal_active_next;
      cal_failed_reg <= cal_failed_next;
      trg_armed_reg <= trg_armed_next;
      hwt_d_reg <= hw_conversion_trigger;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence cal_finish_s;
    cal_active_reg ##1 !cal_active_reg;
  endsequence

  gated_no_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_reg == IDLE && !clk_gate) |=> state_reg == IDLE)
    else $error("conversion started with clock gated");
  sw_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_reg == IDLE && sc1_write && clk_gate && !trigger_source_select) |=>
    state_reg == CONV)
    else $error("software write did not start conversion");
  hw_ignore_sw_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_reg == IDLE && trigger_source_select && !hw_edge && !cal_start) |=>
    state_reg == IDLE)
    else $error("hardware mode started without trigger edge");
  unused_vrefl_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!differential_select && channel_select_field == 5'h1F) |->
    mux_source == adc_ctrl_pkg::SRC_VREFL)
    else $error("unused channel not on low reference");
  ref_reserved_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reference_select == adc_ctrl_pkg::REF_RES |-> ref_pair == adc_ctrl_pkg::REF_EXT)
    else $error("reserved reference not default");
  cal_status_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cal_finish_s |-> !busy &&
    (cal_failed_reg == ($past(mean[15:0]) > adc_ctrl_pkg::CAL_LIMIT)))
    else $error("calibration status moved after completion");
  cal_offset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_reg == DONE && cal_active_reg) |=>
    offset_reg == $past(mean[15:0]))
    else $error("offset not stored after calibration");
  avg_count_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_reg == DONE && !avg_enable && !cal_active_reg) |->
    (nsamp_reg == 6'h1))
    else $error("averaging count used while disabled");

endmodule : adc_unit

// ==== design/adc_ctrl_top.sv ====
// Two-unit converter control with APB register file
`timescale 1ns/1ns
module adc_ctrl_top (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:1] delay_block_trigger,
  input wire logic [1:0] hw_trigger_select_event,
  input wire logic alt_tick,
  input wire logic async_tick,
  input wire logic [15:0] sample_data_0,
  input wire logic [15:0] sample_data_1,
  output logic [5:0] mux_source_0,
  output logic [5:0] mux_source_1,
  output logic [1:0] differential_select_pair,
  output logic [3:0] ref_pair,
  output logic [1:0] conversion_irq
);

  logic rst_meta_reg, rst_n;
  logic [1:0] gate_reg, gate_next;
  logic [7:0] sc1_reg [2], sc1_next [2];
  logic [7:0] sc2_reg [2], sc2_next [2];
  logic [9:0] cfg_reg [2], cfg_next [2];
  logic [31:0] cmp_reg [2], cmp_next [2];
  logic [1:0] sc1_wr, cal_go, coco_clr, coco, cal_act, cal_fail, busy;
  logic [15:0] result [2], offset [2];
  logic [31:0] rdata_next;
  logic [31:0] prdata_reg;
  logic wr, rd_ok;
  logic [2:0] reg_sel;
  logic unit_sel;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // APB decode, zero wait states
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign wr = psel & penable & pwrite;
  assign unit_sel = paddr[5];
  assign reg_sel = paddr[4:2];
  assign rd_ok = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0) &&
                 !(paddr[5] && reg_sel == 3'h0);
  assign pslverr = psel & penable & ~rd_ok;
  assign prdata = prdata_reg;

  // Register next values
  always_comb begin
    gate_next = gate_reg;
    sc1_wr = 2'h0;
    cal_go = 2'h0;
    coco_clr = 2'h0;
    rdata_next = prdata_reg;
    for (int u = 0; u < 2; u++) begin
      sc1_next[u] = sc1_reg[u];
      sc2_next[u] = sc2_reg[u];
      cfg_next[u] = cfg_reg[u];
      cmp_next[u] = cmp_reg[u];
    end
    if (wr && rd_ok) begin
      if (paddr == adc_ctrl_pkg::OFF_CLOCK_GATE) begin
        gate_next = pwdata[1:0];
      end else begin
        unique case ({3'h0, reg_sel, 2'h0})
          adc_ctrl_pkg::OFF_SC1_U0: begin
            sc1_next[unit_sel] = {1'b0, pwdata[6:0]};
            sc1_wr[unit_sel] = 1'b1;
          end
          adc_ctrl_pkg::OFF_SC2_U0: sc2_next[unit_sel] = pwdata[7:0];
          adc_ctrl_pkg::OFF_CFG_U0: begin
            cfg_next[unit_sel] = pwdata[9:0];
            cal_go[unit_sel] = pwdata[adc_ctrl_pkg::CFG_CAL];
            coco_clr[unit_sel] = 1'b0;
          end
          adc_ctrl_pkg::OFF_CMP_U0: cmp_next[unit_sel] = pwdata;
          default: ;
        endcase
      end
    end
    // Reading the result clears the completion flag
    if (psel && penable && !pwrite && reg_sel == 3'h5) coco_clr[unit_sel] = 1'b1;
    if (psel && !penable && !pwrite) begin
      unique case ({3'h0, reg_sel, 2'h0})
        adc_ctrl_pkg::OFF_CLOCK_GATE: rdata_next = {30'h0, gate_reg};
        adc_ctrl_pkg::OFF_SC1_U0:
          rdata_next = {24'h0, coco[unit_sel], sc1_reg[unit_sel][6:0]};
        adc_ctrl_pkg::OFF_SC2_U0: rdata_next = {24'h0, busy[unit_sel], sc2_reg[unit_sel][6:0]};
        adc_ctrl_pkg::OFF_CFG_U0: rdata_next = {20'h0, cal_fail[unit_sel],
                                               cal_act[unit_sel], cfg_reg[unit_sel]};
        adc_ctrl_pkg::OFF_CMP_U0: rdata_next = cmp_reg[unit_sel];
        adc_ctrl_pkg::OFF_RES_U0: rdata_next = {16'h0, result[unit_sel]};
        adc_ctrl_pkg::OFF_OFS_U0: rdata_next = {16'h0, offset[unit_sel]};
        default: rdata_next = 32'h0;
      endcase
      if (unit_sel && reg_sel == 3'h0) rdata_next = 32'h0;
      if (!rd_ok) rdata_next = 32'h0;
    end
  end

  // Registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gate_reg <= 2'h0;
      prdata_reg <= 32'h0;
      for (int u = 0; u < 2; u++) begin
        sc1_reg[u] <= 8'h1F;
        sc2_reg[u] <= 8'h00;
        cfg_reg[u] <= 10'h000;
        cmp_reg[u] <= 32'h0;
      end
    end else begin
      gate_reg <= gate_next;
      prdata_reg <= rdata_next;
      for (int u = 0; u < 2; u++) begin
        sc1_reg[u] <= sc1_next[u];
        sc2_reg[u] <= sc2_next[u];
        cfg_reg[u] <= cfg_next[u];
        cmp_reg[u] <= cmp_next[u];
      end
    end
  end

  // ----------------------------------------------------------------
  // Two independent units
  // ----------------------------------------------------------------
  generate
    for (genvar u = 0; u < 2; u++) begin : g_unit
      logic [5:0] src;
      adc_unit #(.UNIT(u == 1)) u_unit (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_gate(gate_reg[u]),
        .channel_select_field(sc1_reg[u][4:0]),
        .differential_select(sc1_reg[u][adc_ctrl_pkg::SC1_DIFFERENTIAL_SELECT]),
        .sc1_write(sc1_wr[u]),
        .trigger_source_select(sc2_reg[u][adc_ctrl_pkg::SC2_TRG]),
        .reference_select(sc2_reg[u][1:0]),
        .conv_clock_source(cfg_reg[u][1:0]),
        .conv_clock_divider(cfg_reg[u][3:2]),
        .res_mode(cfg_reg[u][5:4]),
        .avg_count(cfg_reg[u][7:6]),
        .avg_enable(cfg_reg[u][adc_ctrl_pkg::CFG_AVGE]),
        .continuous(cfg_reg[u][adc_ctrl_pkg::CFG_CONT]),
        .cal_start(cal_go[u]),
        .cmp_enable(sc2_reg[u][adc_ctrl_pkg::SC2_CMP_EN]),
        .cmp_greater(sc2_reg[u][adc_ctrl_pkg::SC2_CMP_GT]),
        .cmp_range(sc2_reg[u][adc_ctrl_pkg::SC2_CMP_RANGE]),
        .cmp_value(cmp_reg[u][15:0]),
        .cmp_value_hi(cmp_reg[u][31:16]),
        .hw_conversion_trigger(delay_block_trigger[u + 1]),
        .hw_trigger_select_event(hw_trigger_select_event[u]),
        .alt_tick(alt_tick),
        .async_tick(async_tick),
        .sample_data(u == 0 ? sample_data_0 : sample_data_1),
        .coco_clear(coco_clr[u]),
        .mux_source(src),
        .differential_select_pair(differential_select_pair[u]),
        .ref_pair(ref_pair[2*u +: 2]),
        .result_reg(result[u]),
        .offset_reg(offset[u]),
        .coco_reg(coco[u]),
        .cal_active_reg(cal_act[u]),
        .cal_failed_reg(cal_fail[u]),
        .busy(busy[u])
      );
      if (u == 0) begin : g_m0
        assign mux_source_0 = src;
      end else begin : g_m1
        assign mux_source_1 = src;
      end
      // Interrupt request gated by its enable
      assign conversion_irq[u] = coco[u] & sc1_reg[u][adc_ctrl_pkg::SC1_IEN];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  gate_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> gate_reg == 2'h0)
    else $error("clock gates not off after reset");
  irq_enable_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    conversion_irq[0] |-> coco[0] && sc1_reg[0][adc_ctrl_pkg::SC1_IEN])
    else $error("interrupt without enable");

endmodule : adc_ctrl_top

// ==== tb/adc_far_model.sv ====
// Analog input multiplexer model and asynchronous clock tick source
`timescale 1ns/1ns
module adc_far_model (
  input wire logic clk_sys,
  input wire logic [15:0] base,
  input wire logic [5:0] mux_source_0,
  input wire logic [5:0] mux_source_1,
  output logic [15:0] sample_data_0,
  output logic [15:0] sample_data_1,
  output logic async_tick
);
  logic [1:0] cnt_reg = 2'h0;
  // Each source gives its own code; the low reference converts to zero
  assign sample_data_0 = (mux_source_0 == 6'h3F) ? 16'h0000 : base ^ {10'h000, mux_source_0};
  assign sample_data_1 = (mux_source_1 == 6'h3F) ? 16'h0000 : base ^ {10'h000, mux_source_1};
  // Tick every fourth cycle
  always @(posedge clk_sys) cnt_reg <= cnt_reg + 2'h1;
  assign async_tick = (cnt_reg == 2'h0);
endmodule : adc_far_model

// ==== tb/adc_ctrl_top_tb_top.sv ====
// Testbench for the two-unit converter control
`timescale 1ns/1ns
module adc_ctrl_top_tb_top;
  logic clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, atk;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 0, prdata, rd_data, exp_q[$];
  logic [2:1] trg = 2'h0;
  logic [1:0] evt = 2'h0, differential_select_pair, irq;
  logic [15:0] base = 0, s0, s1;
  logic [5:0] m0, m1;
  logic [3:0] ref_pair;
  logic watch = 0, err_cap;
  logic [15:0] tbl[12] = '{16'h2080, 16'h0100, 16'h1A1A, 16'h1B1B, 16'h0F0F, 16'h0222,
    16'h033F, 16'h6181, 16'h4001, 16'h4323, 16'h423F, 16'h5A1A};
  int err_total = 0, total_checks = 0, cyc = 0, seed = 2;
  always #2 clk_sys = ~clk_sys;
  adc_ctrl_top adc_ctrl_top_inst (.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .delay_block_trigger(trg),
    .hw_trigger_select_event(evt), .alt_tick(1'b0), .async_tick(atk), .sample_data_0(s0),
    .sample_data_1(s1), .mux_source_0(m0), .mux_source_1(m1), .differential_select_pair, .ref_pair,
    .conversion_irq(irq));
  adc_far_model adc_far_model_inst (.clk_sys, .base, .mux_source_0(m0), .mux_source_1(m1),
    .sample_data_0(s0), .sample_data_1(s1), .async_tick(atk));
  task chk(input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task xfer(input w, input [7:0] a, input [31:0] d);
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    @(posedge clk_sys);
    while (!pready) @(posedge clk_sys);
    rd_data = prdata;
    err_cap = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : xfer
  task rc(input [7:0] a, input [31:0] e);
    exp_q.push_back(e);
    watch <= 1;
    xfer(0, a, 0);
    watch <= 0;
  endtask : rc
  task wt(input [7:0] a, input int b = 7, input v = 1);
    do xfer(0, a, 0);
    while (rd_data[b] !== v);
  endtask : wt
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  // Read watcher compares against the oldest note
  always @(posedge clk_sys) begin
    if (watch && psel && penable && pready && !pwrite) chk(prdata, exp_q.pop_front());
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      conclude();
    end
  end
  // Main sequence
  initial begin
    base = $random(seed);
    repeat (12) @(posedge clk_sys);
    reset_n <= 1;
    repeat (3) @(posedge clk_sys);
    chk(m0, 6'h3F);
    rc(8'h00, 0);
    xfer(0, 8'h40, 0);
    chk(err_cap, 1);
    $display("reset test done");
    foreach (tbl[i]) begin // Bias supply taken as below analog supply
      xfer(1, {2'h0, tbl[i][14], 5'h04}, {26'h0, tbl[i][13:8]});
      @(negedge clk_sys);
      chk({differential_select_pair[tbl[i][14]], tbl[i][14] ? m1 : m0}, {tbl[i][7], tbl[i][5:0]});
    end
    for (int r = 0; r < 4; r++) begin
      xfer(1, 8'h08, r);
      @(negedge clk_sys);
      chk(ref_pair[1:0], (r == 3) ? 0 : r);
    end
    $display("map test done");
    xfer(1, 8'h04, 32'h1F); // Low reference input for calibration
    xfer(1, 8'h24, 32'h1F);
    xfer(1, 8'h00, 3);
    xfer(1, 8'h0C, 32'h5F0); // Clock and mode set with calibration start
    xfer(1, 8'h2C, 32'h4F0);
    wt(8'h0C, 10, 0);
    wt(8'h2C, 10, 0);
    rc(8'h18, 0);
    rc(8'h0C, 32'h1F0);
    rc(8'h38, 0);
    $display("calibration test done");
    xfer(1, 8'h04, 32'h42);
    xfer(1, 8'h24, 3);
    wt(8'h04);
    chk(irq, 2'h1);
    rc(8'h14, base ^ 16'h22);
    wt(8'h24);
    rc(8'h34, base ^ 16'h23);
    $display("conversion test done");
    xfer(1, 8'h28, 32'h80);
    xfer(1, 8'h24, 32'h1A);
    evt <= 2'h2;
    @(posedge clk_sys);
    trg <= 2'h2;
    wt(8'h24);
    rc(8'h34, base ^ 16'h1A);
    $display("trigger test done");
    conclude();
  end
endmodule : adc_ctrl_top_tb_top
